// [logic/rprom_device.sv]
// Registered 2K x 8 one-time-programmable memory, device end of the pins.
// Assumes pins arrive unsynchronised; every pin is synchronised on i_clock.
//
// What this block does
// [R1] 2048 bytes, 11-bit address, 8-bit output register
// [R2] Clock rising edge loads fetched word to outputs
// [R3] Sync mode: register starts set, outputs off
// [R4] Async mode: enable high floats, low drives
// [R5] Sync mode: off at edge after enable high
// [R6] Sync mode: drive from edge after enable low
// [R7] Outputs hold between edges while address changes
// [R8] Output register is edge triggered
// [R9] Initialize low loads the extra initialize word
// [R10] Initialize word any bit mix, blank clears
// [R11] Initialize overrides clock and all inputs
// [R12] Initialize word seen only once outputs enabled
// [R13] Enable mode defaults async; three programmable items
// [R14] Blank initialize word zero, read via initialize
// [R15] Blank cells neither value; blank check modes
// [R16] Normal mode: enable low drives, high floats
// [R17] Supervoltage initialize: program, verify, inhibit strobes
// [R18] Special select: bit2 high sync, low initialize
// [R19] Supervoltage clock: blank check ones and zeros
// [R20] Program pulse 100 to 10000 microseconds
// [R21] Verify pulse at least 2 microseconds
// [R22] Blank cell reported only in blank check
`timescale 1ns/10ps
`default_nettype none
module rprom_device (
    // Clock and power-on reset
    input  wire logic i_clock,
    input  wire logic i_resetn,
    // Pins towards the host
    rprom_if.dev      pins,
    // Status for the user side
    output logic      o_sync_enable_mode,
    output logic      o_programming
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    localparam int PIN_W = 25;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;

    assign pin_raw = {pins.addr, pins.register_clock, pins.enable_n, pins.init_n,
                      pins.vpp_on_init, pins.vpp_on_clock,
                      pins.vpp_on_special_select_addr_bit1, pins.data_bus};

    // Two flops per pin; only the second stage is read below
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    logic [10:0] addr_s;
    logic        clock_s;
    logic        enable_n_s;
    logic        init_n_s;
    logic        vpp_init_s;
    logic        vpp_clock_s;
    logic        vpp_special_s;
    logic [7:0]  din_s;

    assign addr_s        = pin_sync_q[24:14];
    assign clock_s       = pin_sync_q[13];
    assign enable_n_s    = pin_sync_q[12];
    assign init_n_s      = pin_sync_q[11];
    assign vpp_init_s    = pin_sync_q[10];
    assign vpp_clock_s   = pin_sync_q[9];
    assign vpp_special_s = pin_sync_q[8];
    assign din_s         = pin_sync_q[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    logic clock_last_q;
    logic clock_rise;
    logic mode_normal;
    logic mode_prog;
    logic mode_blank;
    logic prog_pulse;
    logic verify_on;
    logic array_write;
    logic sync_write;
    logic initw_write;
    logic do_init;

    // Edge detect on the synchronised register clock
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            clock_last_q <= 1'b0;
        end else begin
            clock_last_q <= clock_s;
        end
    end

    assign clock_rise  = clock_s & ~clock_last_q;                  // [R8]
    assign mode_normal = ~vpp_init_s & ~vpp_clock_s;
    assign mode_prog   = vpp_init_s & ~vpp_clock_s;                 // [R17]
    assign mode_blank  = vpp_clock_s & ~vpp_init_s & ~init_n_s;     // [R19]
    // program_strobe_n low with verify_strobe_n high programs
    assign prog_pulse  = mode_prog & ~clock_s & enable_n_s;         // [R17]
    assign verify_on   = mode_prog & clock_s & ~enable_n_s;         // [R17]
    assign array_write = prog_pulse & ~vpp_special_s;
    assign sync_write  = prog_pulse & vpp_special_s & addr_s[rprom_pkg::SPECIAL_SEL_BIT]; // [R18]
    assign initw_write = prog_pulse & vpp_special_s & ~addr_s[rprom_pkg::SPECIAL_SEL_BIT]; // [R18]
    assign do_init     = mode_normal & ~init_n_s;                    // [R11]

    ////////////////////////////////////////////////////////////////////////////
    // Programmable storage

    logic [7:0]                   mem_q [rprom_pkg::DEPTH];
    logic [rprom_pkg::DEPTH-1:0]  cell_prog_q;
    logic [7:0]                   init_word_q;
    logic                         sync_cell_q;

    // Main array data; the programmed flags carry the blank state
    always_ff @(posedge i_clock) begin
        if (array_write) begin
            mem_q[addr_s] <= din_s;                                  // [R1]
        end
    end

    // A cell counts as programmed from its first program pulse on
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cell_prog_q <= '0;                                       // [R15]
        end else if (array_write) begin
            cell_prog_q[addr_s] <= 1'b1;
        end
    end

    // Erased bits are zero and programming only ever sets bits
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            init_word_q <= rprom_pkg::INIT_WORD_RESET;               // [R14]
        end else if (initw_write) begin
            init_word_q <= init_word_q | din_s;                      // [R10]
        end
    end

    // Erased cell means asynchronous enable; no data needed to program it
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_cell_q <= rprom_pkg::SYNC_CELL_RESET;               // [R13]
        end else if (sync_write) begin
            sync_cell_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fetch path

    logic       cell_prog;
    logic [7:0] fetch_word;
    logic [7:0] blank_word;

    // Fetch runs every cycle so the next word is ready before the edge
    assign cell_prog  = cell_prog_q[addr_s];
    assign fetch_word = cell_prog ? mem_q[addr_s] : rprom_pkg::BLANK_READ_WORD; // [R22]
    assign blank_word = cell_prog ? mem_q[addr_s] :
                        (enable_n_s ? rprom_pkg::ALL_ZEROS : rprom_pkg::ALL_ONES); // [R19]

    ////////////////////////////////////////////////////////////////////////////
    // Output register and synchronous enable

    logic [7:0] out_q;
    logic       sync_off_q;

    // Initialize wins over the clock; otherwise load only on a rising edge
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            out_q <= rprom_pkg::OUT_REG_RESET;
        end else if (do_init) begin
            out_q <= init_word_q;                                    // [R9]
        end else if (mode_normal && clock_rise) begin
            out_q <= fetch_word;                                     // [R2]
        end
    end

    // Starts set so a sync-mode part powers up floating
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_off_q <= rprom_pkg::SYNC_OFF_RESET;                 // [R3]
        end else if (mode_normal && !do_init && clock_rise) begin
            sync_off_q <= enable_n_s;                                // [R5] [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data pin drive

    logic       drive_d;
    logic [7:0] word_d;
    logic       dout_oe_q;
    logic [7:0] dout_q;

    // Outputs only change here between register loads, so they hold steady
    always_comb begin
        drive_d = 1'b0;
        word_d  = out_q;                                             // [R7]
        if (mode_normal) begin
            // Async mode follows the pin; sync mode follows the clocked flag
            drive_d = sync_cell_q ? ~sync_off_q : ~enable_n_s;       // [R4] [R16] [R12]
        end else if (verify_on) begin
            drive_d = 1'b1;
            word_d  = fetch_word;
        end else if (mode_blank) begin
            drive_d = 1'b1;
            word_d  = blank_word;
        end
    end

    // Registered pin drive costs a cycle but keeps the pins glitch free
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            dout_oe_q <= 1'b0;
            dout_q    <= rprom_pkg::OUT_REG_RESET;
        end else begin
            dout_oe_q <= drive_d;
            dout_q    <= word_d;
        end
    end

    assign pins.dev_data    = dout_q;
    assign pins.dev_data_oe = dout_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Status

    assign o_sync_enable_mode = sync_cell_q;
    assign o_programming      = mode_prog;

endmodule
`default_nettype wire

// [logic/rprom_host.sv]
// Controller and programmer end of the PROM pins.
// Assumes the user side holds i_cmd_valid until o_cmd_ready accepts it.
`timescale 1ns/10ps
`default_nettype none
module rprom_host #(
    parameter int unsigned PROG_PULSE_CYC = rprom_pkg::PROG_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_resetn,
    // Command
    input  wire logic                     i_cmd_valid,
    input  wire rprom_pkg::rprom_cmd_type i_cmd,
    input  wire logic [10:0]              i_addr,
    input  wire logic [7:0]               i_wdata,
    output logic                          o_cmd_ready,
    // Answer
    output logic                          o_rdata_valid,
    output logic [7:0]                    o_rdata,
    // Pins towards the device
    rprom_if.host                         pins
);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_SETUP   = 5'b00010,
        ST_STROBE  = 5'b00100,
        ST_RECOVER = 5'b01000,
        ST_VERIFY  = 5'b10000
    } rprom_state_type;

    rprom_state_type          state_q;
    rprom_pkg::rprom_cmd_type cmd_q;
    logic [10:0]              addr_q;
    logic [7:0]               wdata_q;
    logic [rprom_pkg::CNT_W-1:0] cnt_q;
    logic                     is_prog;
    logic [rprom_pkg::CNT_W-1:0] strobe_len;

    assign is_prog = (cmd_q == rprom_pkg::CMD_PROG) || (cmd_q == rprom_pkg::CMD_PROG_SYNC) ||
                     (cmd_q == rprom_pkg::CMD_PROG_INIT);
    // Program strobe uses the shortest legal pulse to save time
    assign strobe_len = is_prog ? rprom_pkg::CNT_W'(PROG_PULSE_CYC - 1) :
                                  rprom_pkg::CNT_W'(rprom_pkg::SETUP_CYC - 1);
    assign o_cmd_ready = (state_q == ST_IDLE);

    // Each phase lasts its count, then moves on
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_IDLE;
            cmd_q   <= rprom_pkg::CMD_READ;
            addr_q  <= '0;
            wdata_q <= '0;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (i_cmd_valid) begin
                        state_q <= ST_SETUP;
                        cmd_q   <= i_cmd;
                        addr_q  <= i_addr;
                        wdata_q <= i_wdata;
                        cnt_q   <= rprom_pkg::CNT_W'(rprom_pkg::SETUP_CYC - 1);
                    end
                end
                ST_SETUP: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == '0) begin
                        state_q <= ST_STROBE;
                        cnt_q   <= strobe_len;
                    end
                end
                ST_STROBE: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == '0) begin
                        state_q <= ST_RECOVER;
                        cnt_q   <= rprom_pkg::CNT_W'(rprom_pkg::SETUP_CYC - 1);
                    end
                end
                ST_RECOVER: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == '0) begin
                        state_q <= ST_VERIFY;
                        cnt_q   <= rprom_pkg::CNT_W'(rprom_pkg::VERIFY_CYC - 1);
                    end
                end
                ST_VERIFY: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == '0) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin levels

    logic [15:0] pin_d;
    logic [15:0] pin_q;
    logic        busy;
    logic        strobe;

    assign busy   = (state_q != ST_IDLE);
    assign strobe = (state_q == ST_STROBE);

    // Bits: 15 clock, 14 enable_n, 13 init_n, 12 vpp init, 11 vpp clock, 10 vpp special, 9 data oe
    always_comb begin
        pin_d = {1'b0, 1'b1, 1'b1, 7'h00, 6'h00};
        if (busy) begin
            case (cmd_q)
                rprom_pkg::CMD_READ: begin
                    pin_d[14] = 1'b0;
                    pin_d[15] = strobe;
                end
                rprom_pkg::CMD_INIT: begin
                    pin_d[14] = 1'b0;
                    pin_d[13] = ~strobe;
                end
                rprom_pkg::CMD_BLANK_ONES, rprom_pkg::CMD_BLANK_ZEROS: begin
                    pin_d[14] = (cmd_q == rprom_pkg::CMD_BLANK_ZEROS);
                    pin_d[13] = 1'b0;
                    pin_d[11] = 1'b1;
                end
                default: begin
                    // Program strobe low only in its phase; verify low only last
                    pin_d[15] = ~strobe;                             // [R20]
                    pin_d[14] = (state_q != ST_VERIFY);              // [R21]
                    pin_d[12] = 1'b1;
                    pin_d[10] = (cmd_q != rprom_pkg::CMD_PROG);
                    pin_d[9]  = (cmd_q != rprom_pkg::CMD_PROG_SYNC) && (state_q != ST_VERIFY);
                end
            endcase
        end
    end

    // Control pins leave from flops; the address is a mux of the flopped cmd_q and addr_q
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_q <= 16'h6000;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign pins.register_clock                  = pin_q[15];
    assign pins.enable_n                        = pin_q[14];
    assign pins.init_n                          = pin_q[13];
    assign pins.vpp_on_init                     = pin_q[12];
    assign pins.vpp_on_clock                    = pin_q[11];
    assign pins.vpp_on_special_select_addr_bit1 = pin_q[10];
    assign pins.host_data_oe                    = pin_q[9];
    assign pins.host_data                       = wdata_q;
    // Bit 2 picks sync cell or initialize word for the special cells
    assign pins.addr = (cmd_q == rprom_pkg::CMD_PROG_SYNC) ? (addr_q | 11'h004) :
                       (cmd_q == rprom_pkg::CMD_PROG_INIT) ? (addr_q & 11'h7fb) : addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Answer capture

    logic [7:0] din_meta_q;
    logic [7:0] din_sync_q;

    // Data pins come from the other end, so synchronise before sampling
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            din_meta_q    <= '0;
            din_sync_q    <= '0;
            o_rdata       <= '0;
            o_rdata_valid <= 1'b0;
        end else begin
            din_meta_q    <= pins.data_bus;
            din_sync_q    <= din_meta_q;
            o_rdata_valid <= (state_q == ST_VERIFY) && (cnt_q == '0);
            if ((state_q == ST_VERIFY) && (cnt_q == '0)) begin
                o_rdata <= din_sync_q;
            end
        end
    end

endmodule
`default_nettype wire

// [logic/rprom_if.sv]
// Pin bundle between the PROM and its controller or programmer.
// The shared data pins are resolved here from the two output enables.
`timescale 1ns/10ps
`default_nettype none
interface rprom_if;
    // Address and control pins, driven by the host
    logic [10:0] addr;
    logic        register_clock;
    logic        enable_n;
    logic        init_n;
    logic        vpp_on_init;
    logic        vpp_on_clock;
    logic        vpp_on_special_select_addr_bit1;
    // Data pins, split per driver
    logic [7:0]  host_data;
    logic        host_data_oe;
    logic [7:0]  dev_data;
    logic        dev_data_oe;
    logic [7:0]  data_bus;

    // Device wins a clash; an undriven bus reads as zero
    assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'h00);

    modport dev (
        input  addr, register_clock, enable_n, init_n,
        input  vpp_on_init, vpp_on_clock, vpp_on_special_select_addr_bit1,
        input  data_bus,
        output dev_data, dev_data_oe
    );

    modport host (
        output addr, register_clock, enable_n, init_n,
        output vpp_on_init, vpp_on_clock, vpp_on_special_select_addr_bit1,
        output host_data, host_data_oe,
        input  data_bus
    );
endinterface
`default_nettype wire

// [logic/rprom_pkg.sv]
// Shared constants and types for the registered PROM pin link.
// Assumes a single 100 MHz clock on both ends of the link.
package rprom_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Array geometry
    localparam int ADDR_W          = 11;
    localparam int DATA_W          = 8;
    localparam int DEPTH           = 2048;
    // Address bit that picks the sync enable cell (high) or the initialize word (low)
    localparam int SPECIAL_SEL_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] INIT_WORD_RESET = 8'h00;
    localparam logic [7:0] OUT_REG_RESET   = 8'h00;
    localparam logic       SYNC_CELL_RESET = 1'b0;
    localparam logic       SYNC_OFF_RESET  = 1'b1;
    // What a normal read of a never programmed cell returns
    localparam logic [7:0] BLANK_READ_WORD = 8'h00;
    localparam logic [7:0] ALL_ONES        = 8'hff;
    localparam logic [7:0] ALL_ZEROS       = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_PP_MIN_US   = 100;
    localparam int T_PP_MAX_US   = 10000;
    localparam int T_VP_MIN_NS   = 2000;
    localparam int T_SETUP_NS    = 1000;
    localparam int PROG_PULSE_CYC     = (T_PP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_PULSE_MAX_CYC = (T_PP_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int VERIFY_CYC    = (T_VP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Host commands
    typedef enum logic [2:0] {
        CMD_READ        = 3'h0,
        CMD_INIT        = 3'h1,
        CMD_PROG        = 3'h2,
        CMD_PROG_SYNC   = 3'h3,
        CMD_PROG_INIT   = 3'h4,
        CMD_BLANK_ONES  = 3'h5,
        CMD_BLANK_ZEROS = 3'h6
    } rprom_cmd_type;

endpackage

// [tb/registered_prom_read_program_bench.sv]
// Bench joining host and device ends through the pin interface.
// Assumes the host answers every command within 11000 cycles.
`timescale 1ns/10ps
`default_nettype none
module registered_prom_read_program_bench;
    logic                     i_clock;
    logic                     i_resetn;
    logic                     cmd_valid;
    rprom_pkg::rprom_cmd_type cmd;
    logic [10:0]              cmd_addr;
    logic [7:0]               wdata;
    logic                     cmd_ready;
    logic                     rdata_valid;
    logic [7:0]               rdata;
    logic                     sync_mode;
    logic                     programming;
    logic                     prog_seen;
    int                       err_total;
    int                       n_tests;
    int                       cycles;
    logic [10:0]              a_tab [3] = '{11'h000, 11'h7ff, 11'h005};
    logic [7:0]               d_tab [3] = '{8'ha5, 8'h3c, 8'h81};
    ////////////////////////////////////////////////////////////
    // Full program pulses keep the host within its rules
    rprom_if rprom_if_i ();
    rprom_device rprom_device_i (.i_clock(i_clock), .i_resetn(i_resetn),
        .pins(rprom_if_i.dev), .o_sync_enable_mode(sync_mode), .o_programming(programming));
    rprom_host rprom_host_i (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_addr(cmd_addr), .i_wdata(wdata),
        .o_cmd_ready(cmd_ready), .o_rdata_valid(rdata_valid), .o_rdata(rdata),
        .pins(rprom_if_i.host));
    rprom_chk rprom_chk_i (.i_clock(i_clock), .i_resetn(i_resetn), .sync_mode(sync_mode),
        .register_clock(rprom_if_i.register_clock), .enable_n(rprom_if_i.enable_n),
        .init_n(rprom_if_i.init_n), .vpp_on_init(rprom_if_i.vpp_on_init),
        .vpp_on_clock(rprom_if_i.vpp_on_clock), .dev_data_oe(rprom_if_i.dev_data_oe),
        .dev_data(rprom_if_i.dev_data));
    ////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            results();
        end
    end
    // Latches that program mode was reported
    always @(posedge i_clock) prog_seen <= i_resetn && (prog_seen || programming);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One command, held until taken, then wait for its answer
    task automatic run(input rprom_pkg::rprom_cmd_type c, input logic [10:0] a,
                       input logic [7:0] d);
        int k;
        cmd = c;
        cmd_addr = a;
        wdata = d;
        cmd_valid = 1'b1;
        do @(posedge i_clock); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        for (k = 0; k < 11000 && rdata_valid !== 1'b1; k++) @(posedge i_clock);
        #1;
        if (k == 11000) check(8'h00, 8'h01);
    endtask
    task automatic gap();
        repeat (10) @(posedge i_clock);
        #1;
    endtask
    task automatic t_blank();
        check({7'h00, sync_mode}, 8'h00);
        check({7'h00, prog_seen}, 8'h00);
        run(rprom_pkg::CMD_BLANK_ONES, 11'h005, 8'h00);
        check(rdata, rprom_pkg::ALL_ONES);
        run(rprom_pkg::CMD_BLANK_ZEROS, 11'h005, 8'h00);
        check(rdata, rprom_pkg::ALL_ZEROS);
        run(rprom_pkg::CMD_READ, 11'h005, 8'h00);
        check(rdata, rprom_pkg::BLANK_READ_WORD);
        $display("test blank done");
    endtask
    task automatic t_array();
        for (int i = 0; i < 3; i++) begin
            run(rprom_pkg::CMD_PROG, a_tab[i], d_tab[i]);
            check(rdata, d_tab[i]);
        end
        for (int i = 0; i < 3; i++) begin
            run(rprom_pkg::CMD_READ, a_tab[i], 8'h00);
            check(rdata, d_tab[i]);
        end
        gap();
        check({7'h00, rprom_if_i.dev_data_oe}, 8'h00);
        check({6'h00, prog_seen, programming}, 8'h02);
        $display("test array done");
    endtask
    task automatic t_init();
        run(rprom_pkg::CMD_INIT, 11'h000, 8'h00);
        check(rdata, 8'h00);
        run(rprom_pkg::CMD_PROG_INIT, 11'h000, 8'h90);
        run(rprom_pkg::CMD_INIT, 11'h000, 8'h00);
        check(rdata, 8'h90);
        run(rprom_pkg::CMD_PROG_INIT, 11'h000, 8'hff);
        run(rprom_pkg::CMD_INIT, 11'h000, 8'h00);
        check(rdata, 8'hff);
        run(rprom_pkg::CMD_READ, 11'h000, 8'h00);
        check(rdata, 8'ha5);
        $display("test init done");
    endtask
    task automatic t_sync();
        run(rprom_pkg::CMD_PROG_SYNC, 11'h000, 8'h00);
        check({7'h00, sync_mode}, 8'h01);
        run(rprom_pkg::CMD_READ, 11'h7ff, 8'h00);
        check(rdata, 8'h3c);
        gap();
        check({7'h00, rprom_if_i.dev_data_oe}, 8'h01);
        $display("test sync done");
    endtask
    task automatic results();
        $display("tests=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        i_resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd = rprom_pkg::CMD_READ;
        cmd_addr = 11'h000;
        wdata = 8'h00;
        err_total = 0;
        n_tests = 0;
        cycles = 0;
        repeat (16) @(posedge i_clock);
        #1 i_resetn = 1'b1;
        t_blank();
        t_array();
        t_init();
        t_sync();
        results();
    end
endmodule
`default_nettype wire

// [tb/rprom_chk.sv]
// Checker on the PROM pin link between the two design ends.
// Assumes one clock, active low reset and the device mode flag.
`timescale 1ns/10ps
`default_nettype none
module rprom_chk (
    // Clock, reset and mode
    input wire logic       i_clock,
    input wire logic       i_resetn,
    input wire logic       sync_mode,
    // Pins
    input wire logic       register_clock,
    input wire logic       enable_n,
    input wire logic       init_n,
    input wire logic       vpp_on_init,
    input wire logic       vpp_on_clock,
    input wire logic       dev_data_oe,
    input wire logic [7:0] dev_data
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////
    // Windows of 6 or 8 cycles clear the two-flop pin latency
    logic normal;
    assign normal = !vpp_on_init && !vpp_on_clock && init_n;
    logic prog;
    assign prog = vpp_on_init && !vpp_on_clock;
    sequence s_sync_rise;
        sync_mode && normal && !enable_n && $rose(register_clock);
    endsequence
    sequence s_quiet;
        (normal && !register_clock && dev_data_oe) [*8];
    endsequence
    property p_async_off;
        (normal && enable_n && !sync_mode) [*6] |-> !dev_data_oe;
    endproperty
    property p_async_on;
        (normal && !enable_n && !sync_mode) [*6] |-> dev_data_oe;
    endproperty
    property p_idle_hold;
        s_quiet |=> $stable(dev_data) || !dev_data_oe;
    endproperty
    property p_sync_on;
        s_sync_rise |-> ##[3:5] dev_data_oe;
    endproperty
    property p_sync_hold;
        s_quiet ##0 sync_mode |=> dev_data_oe;
    endproperty
    property p_init_hold;
        (!init_n && !vpp_on_init && !vpp_on_clock) [*6] |=> $stable(dev_data) || !dev_data_oe;
    endproperty
    property p_blank_ones;
        (vpp_on_clock && !init_n && !enable_n) [*6] |-> dev_data_oe && dev_data == 8'hff;
    endproperty
    property p_prog_float;
        (prog && enable_n) [*6] |-> !dev_data_oe;
    endproperty
    property p_verify_out;
        (prog && !enable_n && register_clock) [*6] |-> dev_data_oe;
    endproperty
    a_async_off: assert property (p_async_off)
        else $error("outputs driven while disabled");
    a_async_on: assert property (p_async_on)
        else $error("outputs floating while enabled");
    a_idle_hold: assert property (p_idle_hold)
        else $error("outputs changed without clock edge");
    a_sync_on: assert property (p_sync_on)
        else $error("sync mode outputs not driven after edge");
    a_sync_hold: assert property (p_sync_hold)
        else $error("sync mode outputs dropped without edge");
    a_init_hold: assert property (p_init_hold)
        else $error("register moved while initialize low");
    a_blank_ones: assert property (p_blank_ones)
        else $error("blank check ones wrong");
    a_prog_float: assert property (p_prog_float)
        else $error("outputs driven in program or inhibit");
    a_verify_out: assert property (p_verify_out)
        else $error("outputs floating in verify");
endmodule
`default_nettype wire
